// [src/sync_slave_rx.sv]
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sync_slave_rx
   import sync_rx_pkg::*;
#(
   parameter int FIFO_DEPTH = 2
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire logic serial_clock_pin_in,
   input wire logic serial_data_pin_in,
   output logic receive_complete_flag_out,
   output logic irq_out
);
   localparam int AW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
   localparam int CW = $clog2(FIFO_DEPTH + 1);

   // pointers wrap on their own only for a power-of-two depth
   if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("FIFO_DEPTH must be a power of two, at least 2");
   end

   // configuration registers
   logic [7:0] rsc_r;
   logic [7:0] tsc_r;
   logic [7:0] bc_r;
   logic [7:0] div_lo_r;
   logic [7:0] div_hi_r;
   logic [7:0] irq_stat_r;
   logic [7:0] irq_mask_r;
   logic overrun_r;
   // synchronisers
   logic [1:0] ck_sync_r;
   logic [1:0] dt_sync_r;
   logic ck_prev_r;
   // shifter
   logic [8:0] shift_r;
   logic [3:0] bit_cnt_r;
   // fifo control
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [CW-1:0] count_r;
   logic [8:0] head_data;

   // decoding
   wire port_en = rsc_r[RSC_PORT_EN];
   wire cont_rx = rsc_r[RSC_CONT_RX];
   wire nine_bit = rsc_r[RSC_NINE_BIT];
   wire wr_rsc = wr_in && addr_in == REG_RX_STATUS_CTRL;
   wire wr_irq_stat = wr_in && addr_in == REG_IRQ_STATUS;
   wire rd_data = rd_in && addr_in == REG_RX_DATA;
   wire cont_clear = wr_rsc && !wdata_in[RSC_CONT_RX];
   wire en_clear = wr_rsc && !wdata_in[RSC_PORT_EN];
   wire rx_active = port_en && cont_rx && !overrun_r;
   // synchronised levels; polarity applied after the second flop
   wire ck_lvl = ck_sync_r[1] ^ bc_r[BC_CLK_POL];
   wire dt_lvl = dt_sync_r[1] ^ bc_r[BC_DATA_POL];
   wire ck_edge = ck_lvl && !ck_prev_r;
   wire [3:0] char_len = nine_bit ? BITS_NINE : BITS_EIGHT;
   wire last_bit = bit_cnt_r == char_len - 4'h1;
   wire char_done = rx_active && ck_edge && last_bit;
   wire fifo_full = count_r == CW'(FIFO_DEPTH);
   wire fifo_empty = count_r == '0;
   wire push = char_done && !fifo_full;
   wire overflow = char_done && fifo_full;
   wire pop = rd_data && !fifo_empty;
   wire [8:0] char_word = nine_bit ? {dt_lvl, shift_r[8:1]} : {1'b0, dt_lvl, shift_r[8:2]};
   wire [7:0] rsc_read = {rsc_r[7:3], 1'b0, overrun_r, head_data[8] & nine_bit};
   wire [7:0] bc_read = {bc_r[7], !rx_active, bc_r[5:3], 1'b0, bc_r[1:0]};
   wire [7:0] irq_events = {6'h00, overflow, push};

   rx_fifo_mem #(
      .WIDTH(9),
      .DEPTH(FIFO_DEPTH),
      .AW(AW)
   ) u_mem (
      .clk_in(clk_in),
      .ce_in(ce_in),
      .wr_en_in(push),
      .wr_addr_in(wr_ptr_r),
      .wr_data_in(char_word),
      .rd_addr_in(pop ? rd_ptr_r + AW'(1) : rd_ptr_r),
      .rd_data_out(head_data)
   );

   // pin synchronisers; first flop feeds only the second
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         ck_sync_r <= 2'h0;
         dt_sync_r <= 2'h0;
         ck_prev_r <= 1'b0;
      end else if (ce_in) begin
         ck_sync_r <= {ck_sync_r[0], serial_clock_pin_in};
         dt_sync_r <= {dt_sync_r[0], serial_data_pin_in};
         ck_prev_r <= ck_lvl;
      end
   end

   // lsb-first shifter; restarts when the receiver stops
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         shift_r <= 9'h000;
         bit_cnt_r <= 4'h0;
      end else if (ce_in) begin
         if (!rx_active) begin
            bit_cnt_r <= 4'h0;
         end else if (ck_edge) begin
            shift_r <= {dt_lvl, shift_r[8:1]};
            bit_cnt_r <= last_bit ? 4'h0 : bit_cnt_r + 4'h1;
         end
      end
   end

   // fifo pointers; port disable flushes everything
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else if (ce_in) begin
         if (!port_en) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
         end else begin
            if (push) wr_ptr_r <= wr_ptr_r + AW'(1);
            if (pop) rd_ptr_r <= rd_ptr_r + AW'(1);
            count_r <= count_r + CW'(push) - CW'(pop);
         end
      end
   end

   // overrun latches until cont rx or port enable drops
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         overrun_r <= 1'b0;
      end else if (ce_in) begin
         if (cont_clear || en_clear || !port_en) begin
            overrun_r <= 1'b0;
         end else if (overflow) begin
            overrun_r <= 1'b1;
         end
      end
   end

   // software-written registers, masked to implemented bits
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         rsc_r <= RSC_RESET;
         tsc_r <= TSC_RESET;
         bc_r <= BC_RESET;
         div_lo_r <= DIV_RESET;
         div_hi_r <= DIV_RESET;
         irq_mask_r <= MASK_RESET;
      end else if (ce_in && wr_in) begin
         unique case (addr_in)
            REG_RX_STATUS_CTRL: rsc_r <= wdata_in & RSC_WR_MASK;
            REG_TX_STATUS_CTRL: tsc_r <= wdata_in & TSC_WR_MASK;
            REG_BAUD_CTRL: bc_r <= wdata_in & BC_WR_MASK;
            REG_DIV_LOW: div_lo_r <= wdata_in;
            REG_DIV_HIGH: div_hi_r <= wdata_in;
            REG_IRQ_MASK: irq_mask_r <= wdata_in & IRQ_MASK_BITS;
            default: ;
         endcase
      end
   end

   // sticky events; a new event wins over a write-one clear
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         irq_stat_r <= 8'h00;
      end else if (ce_in) begin
         irq_stat_r <= (irq_stat_r & ~(wr_irq_stat ? wdata_in : 8'h00)) | irq_events;
      end
   end

   // read mux, data valid one cycle after the strobe
   logic [7:0] rd_mux;
   always_comb begin
      unique case (addr_in)
         REG_RX_DATA: rd_mux = head_data[7:0];
         REG_RX_STATUS_CTRL: rd_mux = rsc_read;
         REG_TX_STATUS_CTRL: rd_mux = tsc_r;
         REG_BAUD_CTRL: rd_mux = bc_read;
         REG_DIV_LOW: rd_mux = div_lo_r;
         REG_DIV_HIGH: rd_mux = div_hi_r;
         REG_IRQ_STATUS: rd_mux = irq_stat_r;
         REG_IRQ_MASK: rd_mux = irq_mask_r;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         rdata_out <= 8'h00;
      end else if (ce_in) begin
         rdata_out <= rd_in ? rd_mux : 8'h00;
      end
   end

   // flag follows fifo contents; interrupt is a level usable as wake-up
   assign receive_complete_flag_out = !fifo_empty;
   assign irq_out = |(irq_stat_r & irq_mask_r);

   a_push_on_done: assert property (@(posedge clk_in) disable iff (!rstn_in)
      ce_in && push && !pop |=> !fifo_empty)
      else $error("completed character not stored");

   a_overrun_sets: assert property (@(posedge clk_in) disable iff (!rstn_in)
      ce_in && overflow && !cont_clear && !en_clear |=> overrun_r)
      else $error("overrun not latched on full fifo");

   a_overrun_clr_cont: assert property (@(posedge clk_in) disable iff (!rstn_in)
      ce_in && cont_clear |=> !overrun_r)
      else $error("overrun survived continuous-receive clear");

   a_port_reset: assert property (@(posedge clk_in) disable iff (!rstn_in)
      ce_in && en_clear |=> ##1 fifo_empty && !overrun_r)
      else $error("port disable did not reset receiver");

   a_halt_overrun: assert property (@(posedge clk_in) disable iff (!rstn_in)
      overrun_r |-> !push)
      else $error("transfer during overrun");

   a_idle_no_shift: assert property (@(posedge clk_in) disable iff (!rstn_in)
      ce_in && !cont_rx |=> bit_cnt_r == 4'h0)
      else $error("shifting while continuous receive off");

   a_irq_level: assert property (@(posedge clk_in) disable iff (!rstn_in)
      ce_in && push && irq_mask_r[IRQ_RX_DONE] && !wr_in |=> irq_out)
      else $error("receive interrupt missing");

   a_nine_len: assert property (@(posedge clk_in) disable iff (!rstn_in)
      ce_in && char_done |-> bit_cnt_r == (nine_bit ? 4'h8 : 4'h7))
      else $error("character ended at wrong bit count");

   a_bc_bit2_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
      !bc_r[2] && !rsc_read[RSC_FRAME_ERR])
      else $error("unimplemented bit set");

   // bit 2 is unimplemented in both registers, so one index serves
   a_unimpl_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
      ce_in && rd_in && (addr_in == REG_BAUD_CTRL || addr_in == REG_RX_STATUS_CTRL)
      |=> !rdata_out[RSC_FRAME_ERR])
      else $error("unimplemented bit read as one");
endmodule : sync_slave_rx
`default_nettype wire

// [shared/sync_rx_pkg.sv]
package sync_rx_pkg;
   // register indices (one port's worth; byte-wide registers)
   localparam logic [3:0] REG_RX_DATA = 4'h0;
   localparam logic [3:0] REG_RX_STATUS_CTRL = 4'h1;
   localparam logic [3:0] REG_TX_STATUS_CTRL = 4'h2;
   localparam logic [3:0] REG_BAUD_CTRL = 4'h3;
   localparam logic [3:0] REG_DIV_LOW = 4'h4;
   localparam logic [3:0] REG_DIV_HIGH = 4'h5;
   localparam logic [3:0] REG_IRQ_STATUS = 4'h6;
   localparam logic [3:0] REG_IRQ_MASK = 4'h7;
   // receive status/control fields
   localparam int RSC_PORT_EN = 7;
   localparam int RSC_NINE_BIT = 6;
   localparam int RSC_SINGLE_RX = 5;
   localparam int RSC_CONT_RX = 4;
   localparam int RSC_ADDR_DET = 3;
   localparam int RSC_FRAME_ERR = 2;
   localparam int RSC_OVERRUN = 1;
   localparam int RSC_NINTH_BIT = 0;
   // transmit status/control fields used here
   localparam int TSC_CLK_SRC = 7;
   localparam int TSC_SYNC_MODE = 4;
   // baud control fields
   localparam int BC_RX_IDLE = 6;
   localparam int BC_DATA_POL = 5;
   localparam int BC_CLK_POL = 4;
   // writable masks; bit 2 of baud control unimplemented
   localparam logic [7:0] BC_WR_MASK = 8'hBB;
   localparam logic [7:0] RSC_WR_MASK = 8'hF8;
   localparam logic [7:0] TSC_WR_MASK = 8'hFF;
   // interrupt status bits
   localparam int IRQ_RX_DONE = 0;
   localparam int IRQ_OVERRUN = 1;
   localparam logic [7:0] IRQ_MASK_BITS = 8'h03;
   // reset values
   localparam logic [7:0] RSC_RESET = 8'h00;
   localparam logic [7:0] TSC_RESET = 8'h00;
   localparam logic [7:0] BC_RESET = 8'h00;
   localparam logic [7:0] DIV_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   // character lengths
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE = 4'h9;
endpackage : sync_rx_pkg

// [src/rx_fifo_mem.sv]
`timescale 1ns/1ps
`default_nettype none
// small receive store; read data come out of a register
module rx_fifo_mem #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 2,
   parameter int AW = 1
) (
   input wire logic clk_in,
   input wire logic ce_in,
   input wire logic wr_en_in,
   input wire logic [AW-1:0] wr_addr_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic [AW-1:0] rd_addr_in,
   output logic [WIDTH-1:0] rd_data_out
);
   logic [WIDTH-1:0] mem_r [DEPTH];
   // a write into the slot being read passes straight through
   wire bypass = wr_en_in && wr_addr_in == rd_addr_in;

   // the address must reach every entry
   if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_size
      $error("DEPTH does not fit the address width");
   end

   // write port
   always_ff @(posedge clk_in) begin
      if (ce_in && wr_en_in) begin
         mem_r[wr_addr_in] <= wr_data_in;
      end
   end

   // registered read; bypass avoids a stale head after push into an empty store
   always_ff @(posedge clk_in) begin
      if (ce_in) begin
         rd_data_out <= bypass ? wr_data_in : mem_r[rd_addr_in];
      end
   end
endmodule : rx_fifo_mem
`default_nettype wire

// [test/sync_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
// far-side master: makes the shift clock only within frames, 800 ns period
module sync_master_model (
   output var logic sck_out,
   output var logic sdo_out
);
   // pins start at an idle level before the first frame
   initial begin
      sck_out = 1'b0;
      sdo_out = 1'b1;
   end

   // one character, lsb first; clock rests at cpol between frames
   task automatic send(input logic [8:0] v, input int n, input logic cpol, input logic dinv);
      int i;
      #37;
      sck_out = cpol;
      for (i = 0; i < n; i++) begin
         sdo_out = v[i] ^ dinv;
         #400 sck_out = ~cpol;
         #400 sck_out = cpol;
      end
      // released line: show the inverse so a late sample cannot pass by luck
      sdo_out = ~sdo_out;
   endtask : send
endmodule : sync_master_model
`default_nettype wire

// [test/sync_slave_rx_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module sync_slave_rx_tb;
   import sync_rx_pkg::*;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic ce_in = 1'b1;
   logic [3:0] addr_in = 4'h0;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [7:0] rdata_out;
   logic sck;
   logic sdo;
   logic flag;
   logic irq;
   logic [7:0] rv;
   int miscompares = 0;
   int n_checks = 0;
   int k;

   // 10 MHz system clock
   always #50 clk_in = ~clk_in;

   // far side drives both pins; the receiver only listens
   sync_master_model m (.sck_out(sck), .sdo_out(sdo));

   // clock enable dropped once to show a frozen write does not land
   sync_slave_rx #(.FIFO_DEPTH(2)) uut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .serial_clock_pin_in(sck), .serial_data_pin_in(sdo),
      .receive_complete_flag_out(flag), .irq_out(irq));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // write: one strobe cycle, then let the update settle
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
      @(negedge clk_in);
   endtask : wr

   // read: data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      rv = rdata_out;
   endtask : rd

   // one frame from the master, then room for sync and push
   task automatic rx(input logic [8:0] v, input int n, input logic cp, input logic di);
      m.send(v, n, cp, di);
      repeat (6) @(posedge clk_in);
      @(negedge clk_in);
   endtask : rx

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude

   // watchdog: the tests need well under 200 us
   initial begin
      #2000000;
      miscompares++;
      conclude();
   end

   initial begin
      repeat (3) @(posedge clk_in);
      rstn_in <= 1'b1;
      // register map, reset values, unimplemented bits
      rd(REG_RX_STATUS_CTRL);
      chk(rv, RSC_RESET);
      rd(REG_IRQ_MASK);
      chk(rv, MASK_RESET);
      wr(REG_BAUD_CTRL, 8'hFF);
      rd(REG_BAUD_CTRL);
      chk(rv & 8'hBF, BC_WR_MASK);
      wr(REG_BAUD_CTRL, 8'h00);
      wr(REG_DIV_LOW, 8'h5A);
      rd(REG_DIV_LOW);
      chk(rv, 8'h5A);
      wr(REG_TX_STATUS_CTRL, 8'h10);
      rd(REG_TX_STATUS_CTRL);
      chk(rv, 8'h10);
      // frozen clock enable: the write must be lost
      @(posedge clk_in);
      ce_in <= 1'b0;
      wr(REG_DIV_LOW, 8'hC3);
      @(posedge clk_in);
      ce_in <= 1'b1;
      rd(REG_DIV_LOW);
      chk(rv, 8'h5A);
      rd(4'h9);
      chk(rv, 8'h00);
      $display("test registers done");
      // 8-bit character with single-receive bit set as well
      wr(REG_IRQ_MASK, 8'h01);
      wr(REG_RX_STATUS_CTRL, 8'hB0);
      rx(9'h0A5, 8, 1'b0, 1'b0);
      chk({7'h00, flag}, 8'h01);
      chk({7'h00, irq}, 8'h01);
      rd(REG_IRQ_STATUS);
      chk(rv, 8'h01);
      rd(REG_RX_DATA);
      chk(rv, 8'hA5);
      chk({7'h00, flag}, 8'h00);
      wr(REG_IRQ_MASK, 8'h00);
      chk({7'h00, irq}, 8'h00);
      wr(REG_IRQ_STATUS, 8'h01);
      rd(REG_IRQ_STATUS);
      chk(rv, 8'h00);
      $display("test eight bit done");
      // 9-bit character: top bit first, then low byte
      wr(REG_RX_STATUS_CTRL, 8'hD0);
      rx(9'h13C, 9, 1'b0, 1'b0);
      rd(REG_RX_STATUS_CTRL);
      chk(rv & 8'h01, 8'h01);
      rd(REG_RX_DATA);
      chk(rv, 8'h3C);
      // receiver off: a frame must leave nothing behind
      wr(REG_RX_STATUS_CTRL, 8'h80);
      rx(9'h044, 8, 1'b0, 1'b0);
      chk({7'h00, flag}, 8'h00);
      $display("test nine bit done");
      // overrun, cleared once by receive enable and once by port enable
      for (k = 0; k < 2; k++) begin
         wr(REG_RX_STATUS_CTRL, 8'h90);
         rx(9'h011, 8, 1'b0, 1'b0);
         rx(9'h022, 8, 1'b0, 1'b0);
         rx(9'h033, 8, 1'b0, 1'b0);
         rd(REG_RX_STATUS_CTRL);
         chk(rv & 8'hFE, 8'h92);
         rd(REG_RX_DATA);
         chk(rv, 8'h11);
         rd(REG_RX_DATA);
         chk(rv, 8'h22);
         chk({7'h00, flag}, 8'h00);
         wr(REG_RX_STATUS_CTRL, (k == 0) ? 8'h80 : 8'h00);
         rd(REG_RX_STATUS_CTRL);
         chk(rv & 8'hFE, (k == 0) ? 8'h80 : 8'h00);
      end
      rd(REG_IRQ_STATUS);
      chk(rv & 8'h02, 8'h02);
      $display("test overrun done");
      // mid-run reset brings sticky status and stored registers back
      @(posedge clk_in);
      rstn_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      rstn_in <= 1'b1;
      rd(REG_IRQ_STATUS);
      chk(rv, 8'h00);
      rd(REG_DIV_LOW);
      chk(rv, DIV_RESET);
      rd(REG_TX_STATUS_CTRL);
      chk(rv, TSC_RESET);
      $display("test reset done");
      // inverted clock and data senses
      wr(REG_BAUD_CTRL, 8'h30);
      wr(REG_RX_STATUS_CTRL, 8'h90);
      rx(9'h093, 8, 1'b1, 1'b1);
      rd(REG_RX_DATA);
      chk(rv, 8'h93);
      $display("test polarity done");
      conclude();
   end
endmodule : sync_slave_rx_tb
`default_nettype wire
